// [zcd_pkg.sv]
// Shared constants for the zero-cross detector control block.
package zcd_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    localparam logic [11:0] CTRL_OFFS   = 12'h91f;
    localparam logic [11:0] STATUS_OFFS = 12'h920;
    localparam logic [11:0] MASK_OFFS   = 12'h921;

    localparam int SOFT_EN_BIT = 7;
    localparam int RESULT_BIT  = 5;
    localparam int FLIP_BIT    = 4;
    localparam int RISE_EN_BIT = 1;
    localparam int FALL_EN_BIT = 0;
    localparam int IRQ_BIT     = 0;

    localparam logic       SOFT_EN_RST = 1'h0;
    localparam logic       FLIP_RST    = 1'h0;
    localparam logic       RISE_EN_RST = 1'h0;
    localparam logic       FALL_EN_RST = 1'h0;
    localparam logic       STATUS_RST  = 1'h0;
    localparam logic       MASK_RST    = 1'h0;
    localparam logic [7:0] RDATA_RST   = 8'h00;

    localparam int SYNC_STAGES = 2;
endpackage : zcd_pkg

// [zcd_edge_if.sv]
// Interface carrying the conditioned detector level and its edges.
`timescale 1ns/1ps
interface zcd_edge_if;
    logic sense_flip;
    logic level;
    logic rise;
    logic fall;

    modport det
    (
        input  sense_flip,
        output level,
        output rise,
        output fall
    );

    modport ctl
    (
        output sense_flip,
        input  level,
        input  rise,
        input  fall
    );
endinterface : zcd_edge_if

// [zcd_edge.sv]
// Synchroniser, polarity adjustment and edge finder for the detector input.
`timescale 1ns/1ps
module zcd_edge
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic det_async,
    zcd_edge_if.det   ev
);
    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic prev_q;

    // Two-stage synchroniser; the first stage feeds only the second.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync1_q <= 1'h0;
            sync2_q <= 1'h0;
        end
        else
        begin
            sync1_q <= det_async;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            level_q <= 1'h0;
            prev_q  <= 1'h0;
        end
        else
        begin
            level_q <= sync2_q ^ ev.sense_flip;
            prev_q  <= level_q;
        end
    end

    assign ev.level = level_q;
    assign ev.rise  = level_q & ~prev_q;
    assign ev.fall  = ~level_q & prev_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_sync_latency: assert property ($rose(sync2_q) |-> $past(det_async, 2))
        else $error("synchronised level rose without input two cycles earlier");
    a_flip_invert: assert property (##1 ev.level == $past(sync2_q ^ ev.sense_flip))
        else $error("detector level not adjusted by the sense flip");
endmodule : zcd_edge

// [zcd_ctrl.sv]
// Control, status and interrupt logic of the zero-cross detector.
`timescale 1ns/1ps
module zcd_ctrl
#(
    parameter int ADDR_W = zcd_pkg::ADDR_W,
    parameter int DATA_W = zcd_pkg::DATA_W
)
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              zc_config_fuse,
    input  wire logic              det_async,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rd_data_q,
    output logic                   irq_q,
    output logic                   zc_enabled_q,
    output logic                   zc_out_q
);
    zcd_edge_if ev ();

    logic fuse_q;
    logic soft_en_q;
    logic flip_q;
    logic rise_en_q;
    logic fall_en_q;
    logic status_q;
    logic mask_q;

    logic ctrl_wr;
    logic status_wr;
    logic mask_wr;
    logic ctrl_rd;
    logic status_rd;
    logic mask_rd;
    logic flip_chg;
    logic edge_ev;
    logic ev_any;
    logic status_d;
    logic irq_d;
    logic enabled_d;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] rd_data_d;

    zcd_edge u_edge
    (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .det_async (det_async),
        .ev        (ev.det)
    );

    assign ev.sense_flip = flip_q;

    // Address decode for the plain register port.
    always_comb
    begin
        ctrl_wr   = 1'h0;
        status_wr = 1'h0;
        mask_wr   = 1'h0;
        ctrl_rd   = 1'h0;
        status_rd = 1'h0;
        mask_rd   = 1'h0;
        if (addr == ADDR_W'(zcd_pkg::CTRL_OFFS))
        begin
            ctrl_wr = wr_stb;
            ctrl_rd = rd_stb;
        end
        else if (addr == ADDR_W'(zcd_pkg::STATUS_OFFS))
        begin
            status_wr = wr_stb;
            status_rd = rd_stb;
        end
        else if (addr == ADDR_W'(zcd_pkg::MASK_OFFS))
        begin
            mask_wr = wr_stb;
            mask_rd = rd_stb;
        end
    end

    // The fuse is a strap: it is sampled while reset is held and kept after.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fuse_q <= zc_config_fuse;
        end
    end

    // Writable control bits; the result level and unused bits ignore writes.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            soft_en_q <= zcd_pkg::SOFT_EN_RST;
            flip_q    <= zcd_pkg::FLIP_RST;
            rise_en_q <= zcd_pkg::RISE_EN_RST;
            fall_en_q <= zcd_pkg::FALL_EN_RST;
        end
        else if (ctrl_wr)
        begin
            soft_en_q <= wr_data[zcd_pkg::SOFT_EN_BIT];
            flip_q    <= wr_data[zcd_pkg::FLIP_BIT];
            rise_en_q <= wr_data[zcd_pkg::RISE_EN_BIT];
            fall_en_q <= wr_data[zcd_pkg::FALL_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            mask_q <= zcd_pkg::MASK_RST;
        end
        else if (mask_wr)
        begin
            mask_q <= wr_data[zcd_pkg::IRQ_BIT];
        end
    end

    // Enable: the fuse at zero overrides the soft enable.
    assign enabled_d = ~fuse_q | soft_en_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            zc_enabled_q <= 1'h0;
            zc_out_q     <= 1'h0;
        end
        else
        begin
            zc_enabled_q <= enabled_d;
            zc_out_q     <= ev.level;
        end
    end

    // A write that toggles the sense flip is an event by itself.
    assign flip_chg = ctrl_wr & (wr_data[zcd_pkg::FLIP_BIT] != flip_q);

    // Edges count only while the detector is enabled and the edge is enabled.
    assign edge_ev = zc_enabled_q & ((ev.rise & rise_en_q)
                                   | (ev.fall & fall_en_q));
    assign ev_any  = edge_ev | flip_chg;

    // Reading the status register clears the flag; a new event wins.
    always_comb
    begin
        status_d = status_q;
        if (status_rd)
        begin
            status_d = 1'h0;
        end
        if (ev_any)
        begin
            status_d = 1'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            status_q <= zcd_pkg::STATUS_RST;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    assign irq_d = status_d & mask_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_q <= 1'h0;
        end
        else
        begin
            irq_q <= irq_d;
        end
    end

    // Unused bits 6, 3 and 2 read as zero.
    always_comb
    begin
        ctrl_view = '0;
        ctrl_view[zcd_pkg::SOFT_EN_BIT] = soft_en_q;
        ctrl_view[zcd_pkg::RESULT_BIT]  = ev.level;
        ctrl_view[zcd_pkg::FLIP_BIT]    = flip_q;
        ctrl_view[zcd_pkg::RISE_EN_BIT] = rise_en_q;
        ctrl_view[zcd_pkg::FALL_EN_BIT] = fall_en_q;
    end

    // Read data stand only in the cycle after the read strobe.
    always_comb
    begin
        rd_data_d = '0;
        if (ctrl_rd)
        begin
            rd_data_d = ctrl_view;
        end
        else if (status_rd)
        begin
            rd_data_d[zcd_pkg::IRQ_BIT] = status_q;
        end
        else if (mask_rd)
        begin
            rd_data_d[zcd_pkg::IRQ_BIT] = mask_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rd_data_q <= DATA_W'(zcd_pkg::RDATA_RST);
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_flip_write;
        ctrl_wr && (wr_data[zcd_pkg::FLIP_BIT] != flip_q);
    endsequence

    sequence s_clear_read;
        status_rd && !ev_any;
    endsequence

    a_fuse_low_on: assert property (!fuse_q |=> zc_enabled_q)
        else $error("detector not enabled while fuse is clear");
    a_soft_en_on: assert property (fuse_q && soft_en_q |=> zc_enabled_q)
        else $error("detector not enabled by soft enable");
    a_soft_en_off: assert property (fuse_q && !soft_en_q |=> !zc_enabled_q)
        else $error("detector enabled while soft enable is clear");
    a_result_read: assert property (ctrl_rd |=> rd_data_q[5] == $past(ev.level))
        else $error("result level bit does not show detector level");
    a_unused_zero: assert property (ctrl_rd |=> !rd_data_q[6] && !rd_data_q[3] && !rd_data_q[2])
        else $error("unused control bits read nonzero");
    a_rise_flag: assert property (zc_enabled_q && rise_en_q && ev.rise |=> status_q)
        else $error("enabled rising edge did not set flag");
    a_fall_flag: assert property (zc_enabled_q && fall_en_q && ev.fall |=> status_q)
        else $error("enabled falling edge did not set flag");
    a_flag_cause: assert property ($rose(status_q) |-> $past(ev_any))
        else $error("flag set without an enabled event");
    a_flip_event: assert property (s_flip_write ##0 mask_q |=> irq_q)
        else $error("sense flip change did not raise interrupt");
    a_set_beats_clr: assert property (status_rd && ev_any |=> status_q)
        else $error("event lost in the clearing cycle");
    a_read_clears: assert property (s_clear_read |=> !status_q ##1 (status_q == $past(ev_any)))
        else $error("status read did not clear the flag");
    // Only a read may clear the flag; a write to the status address changes nothing.
    a_status_ro: assert property (status_wr && !ev_any |=> status_q == $past(status_q))
        else $error("status write changed the flag");
endmodule : zcd_ctrl

// [zcd_src_model.sv]
// Behavioural model of the AC source that feeds the detector input.
`timescale 1ns/1ps
module zcd_src_model
(
    input  wire logic sys_clk,
    output logic      det_async
);
    initial det_async = 1'h0;

    // Moves the detector level just after a rising edge and holds it there.
    task automatic drive(input logic lvl);
        @(posedge sys_clk);
        det_async <= lvl;
    endtask : drive
endmodule : zcd_src_model

// [tb_zero_cross_detect_control.sv]
// Self-checking bench for the zero-cross detector control block.
`timescale 1ns/1ps
module tb_zero_cross_detect_control;
    logic        sys_clk = 1'h0;
    logic        rst = 1'h1;
    logic        zc_config_fuse = 1'h1;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_stb = 1'h0;
    logic        rd_stb = 1'h0;
    logic [7:0]  rd_data_q;
    logic        irq_q;
    logic        zc_enabled_q;
    logic        zc_out_q;
    logic        det_async;
    int          n_errors = 0;
    int          checked = 0;
    logic [31:0] seed = 32'h00016cd9;
    logic [7:0]  r;
    logic [7:0]  r2;
    logic [7:0]  ctl;
    logic        lvl;
    logic        nl;

    always #20 sys_clk = ~sys_clk;

    zcd_ctrl zcd_ctrl_i
    (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .zc_config_fuse (zc_config_fuse),
        .det_async      (det_async),
        .addr           (addr),
        .wr_data        (wr_data),
        .wr_stb         (wr_stb),
        .rd_stb         (rd_stb),
        .rd_data_q      (rd_data_q),
        .irq_q          (irq_q),
        .zc_enabled_q   (zc_enabled_q),
        .zc_out_q       (zc_out_q)
    );

    zcd_src_model zcd_src_model_i
    (
        .sys_clk   (sys_clk),
        .det_async (det_async)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Expected flag from adjusted levels before and after a change.
    function automatic logic hit(input logic p, input logic n, input logic [7:0] c);
        return (~p & n & c[1]) | (p & ~n & c[0]);
    endfunction : hit

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'h1;
        @(posedge sys_clk);
        wr_stb  <= 1'h0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'h1;
        @(posedge sys_clk);
        rd_stb <= 1'h0;
        #1;
        d = rd_data_q;
    endtask : rd

    task automatic do_reset();
        rst <= 1'h1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'h0;
    endtask : do_reset

    initial
    begin
        #2000000;
        n_errors = n_errors + 1;
        finish_test();
    end

    initial
    begin
        do_reset();
        rd(12'h91f, r);
        chk(r, 8'h00);
        chk({7'h0, zc_enabled_q}, 8'h00);
        chk({6'h0, irq_q, zc_out_q}, 8'h00);
        wr(12'h921, 8'h01);
        wr(12'h91f, 8'h10);
        #1;
        chk({7'h0, irq_q}, 8'h01);
        rd(12'h920, r);
        chk(r, 8'h01);
        chk({7'h0, irq_q}, 8'h00);
        rd(12'h920, r);
        chk(r, 8'h00);
        wr(12'h920, 8'hff);
        wr(12'h922, 8'hff);
        rd(12'h920, r);
        chk(r, 8'h00);
        rd(12'h922, r);
        chk(r, 8'h00);
        wr(12'h91f, 8'h13);
        lvl = 1'h1;
        zcd_src_model_i.drive(lvl);
        repeat (8) @(posedge sys_clk);
        rd(12'h920, r);
        chk(r, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            ctl = {1'h1, 2'h0, i[3], 2'h0, seed[1:0]};
            wr(12'h91f, ctl | {1'h0, seed[4], seed[5], 1'h0, seed[6], seed[7], 2'h0});
            wr(12'h921, {7'h0, seed[2]});
            repeat (8) @(posedge sys_clk);
            rd(12'h920, r);
            rd(12'h921, r);
            chk(r, {7'h0, seed[2]});
            nl = seed[3];
            zcd_src_model_i.drive(nl);
            repeat (8) @(posedge sys_clk);
            #1;
            r2 = {7'h0, hit(lvl ^ ctl[4], nl ^ ctl[4], ctl)};
            chk({7'h0, irq_q}, r2 & {7'h0, seed[2]});
            rd(12'h920, r);
            chk(r, r2);
            rd(12'h91f, r);
            chk(r, ctl | {2'h0, nl ^ ctl[4], 5'h0});
            chk({7'h0, zc_out_q}, {7'h0, nl ^ ctl[4]});
            chk({7'h0, zc_enabled_q}, 8'h01);
            lvl = nl;
        end
        wr(12'h91f, 8'h83);
        for (int d = 0; d < 7; d++)
        begin
            repeat (8) @(posedge sys_clk);
            rd(12'h920, r);
            lvl = ~lvl;
            zcd_src_model_i.drive(lvl);
            repeat (d) @(posedge sys_clk);
            rd(12'h920, r);
            repeat (8) @(posedge sys_clk);
            rd(12'h920, r2);
            chk(r | r2, 8'h01);
        end
        zc_config_fuse <= 1'h0;
        do_reset();
        wr(12'h91f, 8'h03);
        repeat (8) @(posedge sys_clk);
        rd(12'h920, r);
        chk({7'h0, zc_enabled_q}, 8'h01);
        lvl = ~lvl;
        zcd_src_model_i.drive(lvl);
        repeat (8) @(posedge sys_clk);
        rd(12'h920, r);
        chk(r, 8'h01);
        finish_test();
    end
endmodule : tb_zero_cross_detect_control
